// [rtl/ddt_defs.vh]
// register map, field positions, reset values and timing counts of the dual down-count timer
`ifndef DDT_DEFS_VH
`define DDT_DEFS_VH
`define DDT_ADDR_W        4
`define DDT_OFF_CTRL      4'h0
`define DDT_OFF_CNT0_LO   4'h1
`define DDT_OFF_CNT0_HI   4'h2
`define DDT_OFF_RLD0_LO   4'h3
`define DDT_OFF_RLD0_HI   4'h4
`define DDT_OFF_CNT1_LO   4'h5
`define DDT_OFF_CNT1_HI   4'h6
`define DDT_OFF_RLD1_LO   4'h7
`define DDT_OFF_RLD1_HI   4'h8
`define DDT_OFF_IRQ_STAT  4'h9
`define DDT_OFF_IRQ_MASK  4'hA
`define DDT_BIT_ZF1       7
`define DDT_BIT_ZF0       6
`define DDT_BIT_IE1       5
`define DDT_BIT_IE0       4
`define DDT_BIT_OC_HI     3
`define DDT_BIT_OC_LO     2
`define DDT_BIT_CE1       1
`define DDT_BIT_CE0       0
`define DDT_CTRL_RST      6'h00
`define DDT_CNT_RST       16'hFFFF
`define DDT_RLD_RST       16'hFFFF
`define DDT_OC_ADDR       2'h0
`define DDT_OC_TOGGLE     2'h1
`define DDT_OC_LOW        2'h2
`define DDT_OC_HIGH       2'h3
`define DDT_STEP_DIV      16'h0014
`endif

// [rtl/ddt_step_div.v]
// divider making the one-cycle count step enable
`include "ddt_defs.vh"
module ddt_step_div #(
  parameter [15:0] DIV = `DDT_STEP_DIV
) (
  input  wire clk,
  input  wire rst_b,
  output reg  step
);
  reg [15:0] cnt;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt  <= 16'h0000;
      step <= 1'b0;
    end else if (cnt >= DIV - 16'h0001) begin
      cnt  <= 16'h0000;
      step <= 1'b1;
    end else begin
      cnt  <= cnt + 16'h0001;
      step <= 1'b0;
    end
  end
endmodule // ddt_step_div

// [rtl/ddt_channel.v]
// one down-counting channel with reload and zero-reached pulse
`include "ddt_defs.vh"
module ddt_channel (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        step,
  input  wire        enable,
  input  wire        wr_lo,
  input  wire        wr_hi,
  input  wire [7:0]  wdata,
  input  wire [15:0] reload,
  output reg  [15:0] count,
  output reg         zero_hit
);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count    <= `DDT_CNT_RST;
      zero_hit <= 1'b0;
    end else begin
      zero_hit <= 1'b0;
      if (enable && step) begin
        if (count == 16'h0000) begin
          count <= reload;
        end else begin
          count <= count - 16'h0001;
          if (count == 16'h0001) begin
            zero_hit <= 1'b1;
          end
        end
      end else if (!enable) begin
        if (wr_lo) begin
          count[7:0] <= wdata;
        end
        if (wr_hi) begin
          count[15:8] <= wdata;
        end
      end
    end
  end
endmodule // ddt_channel

// [rtl/ddt_top.v]
// control, status and bus slave of the dual down-count timer
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`include "ddt_defs.vh"
module ddt_top #(
  parameter [15:0] STEP_DIV = `DDT_STEP_DIV
) (
  input  wire                   clk,
  input  wire                   rst_b,
  input  wire [`DDT_ADDR_W-1:0] avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [31:0]            avs_writedata,
  input  wire [3:0]             avs_byteenable,
  output reg  [31:0]            avs_readdata,
  output wire                   avs_waitrequest,
  input  wire                   addr_line,
  output wire                   shared_addr_timer_pin,
  output wire                   timer_irq,
  output wire                   irq
);
  reg  [5:0]  ctrl;
  reg         zero_flag_ch1;
  reg         zero_flag_ch0;
  reg         armed_ch1;
  reg         armed_ch0;
  reg  [15:0] reload_timer_ch0;
  reg  [15:0] reload_timer_ch1;
  reg  [1:0]  irq_stat;
  reg  [1:0]  irq_mask;
  reg         tout;
  reg         ack;
  wire        step;
  wire [15:0] count_reg_ch0;
  wire [15:0] count_reg_ch1;
  wire        zero_ch0;
  wire        zero_ch1;
  wire        irq_enable_ch1   = ctrl[`DDT_BIT_IE1];
  wire        irq_enable_ch0   = ctrl[`DDT_BIT_IE0];
  wire [1:0]  out_ctrl         = {ctrl[`DDT_BIT_OC_HI], ctrl[`DDT_BIT_OC_LO]};
  wire        count_enable_ch1 = ctrl[`DDT_BIT_CE1];
  wire        count_enable_ch0 = ctrl[`DDT_BIT_CE0];
  wire        req              = avs_read | avs_write;
  // writes land only at the answering edge, never in the wait cycle
  wire        wr               = avs_write & ack & avs_byteenable[0];
  wire        rd               = avs_read & ~ack;
  wire [7:0]  wd               = avs_writedata[7:0];

  function hit;
    input [`DDT_ADDR_W-1:0] a;
    input [`DDT_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // one wait cycle, answer on the second edge
  assign avs_waitrequest = req & ~ack;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  ddt_step_div #(
    .DIV (STEP_DIV)
  ) u_div (
    .clk   (clk),
    .rst_b (rst_b),
    .step  (step)
  );

  ddt_channel u_ch0 (
    .clk      (clk),
    .rst_b    (rst_b),
    .step     (step),
    .enable   (count_enable_ch0),
    .wr_lo    (wr & hit(avs_address, `DDT_OFF_CNT0_LO)),
    .wr_hi    (wr & hit(avs_address, `DDT_OFF_CNT0_HI)),
    .wdata    (wd),
    .reload   (reload_timer_ch0),
    .count    (count_reg_ch0),
    .zero_hit (zero_ch0)
  );

  ddt_channel u_ch1 (
    .clk      (clk),
    .rst_b    (rst_b),
    .step     (step),
    .enable   (count_enable_ch1),
    .wr_lo    (wr & hit(avs_address, `DDT_OFF_CNT1_LO)),
    .wr_hi    (wr & hit(avs_address, `DDT_OFF_CNT1_HI)),
    .wdata    (wd),
    .reload   (reload_timer_ch1),
    .count    (count_reg_ch1),
    .zero_hit (zero_ch1)
  );

  wire rd_ctrl = rd & hit(avs_address, `DDT_OFF_CTRL);
  wire rd_c0   = rd & (hit(avs_address, `DDT_OFF_CNT0_LO) | hit(avs_address, `DDT_OFF_CNT0_HI));
  wire rd_c1   = rd & (hit(avs_address, `DDT_OFF_CNT1_LO) | hit(avs_address, `DDT_OFF_CNT1_HI));

  // control bits and reload values
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl             <= `DDT_CTRL_RST;
      reload_timer_ch0 <= `DDT_RLD_RST;
      reload_timer_ch1 <= `DDT_RLD_RST;
      irq_mask         <= 2'h0;
    end else if (wr) begin
      if (hit(avs_address, `DDT_OFF_CTRL)) begin
        ctrl <= wd[5:0];
      end
      if (hit(avs_address, `DDT_OFF_RLD0_LO)) begin
        reload_timer_ch0[7:0] <= wd;
      end
      if (hit(avs_address, `DDT_OFF_RLD0_HI)) begin
        reload_timer_ch0[15:8] <= wd;
      end
      if (hit(avs_address, `DDT_OFF_RLD1_LO)) begin
        reload_timer_ch1[7:0] <= wd;
      end
      if (hit(avs_address, `DDT_OFF_RLD1_HI)) begin
        reload_timer_ch1[15:8] <= wd;
      end
      if (hit(avs_address, `DDT_OFF_IRQ_MASK)) begin
        irq_mask <= wd[1:0];
      end
    end
  end

  // zero flags: set wins over the read-sequence clear
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_flag_ch1 <= 1'b0;
      zero_flag_ch0 <= 1'b0;
      armed_ch1     <= 1'b0;
      armed_ch0     <= 1'b0;
    end else begin
      if (rd_ctrl) begin
        armed_ch1 <= zero_flag_ch1;
        armed_ch0 <= zero_flag_ch0;
      end
      if (zero_ch1) begin
        zero_flag_ch1 <= 1'b1;
      end else if (rd_c1 && armed_ch1) begin
        zero_flag_ch1 <= 1'b0;
        armed_ch1     <= 1'b0;
      end
      if (zero_ch0) begin
        zero_flag_ch0 <= 1'b1;
      end else if (rd_c0 && armed_ch0) begin
        zero_flag_ch0 <= 1'b0;
        armed_ch0     <= 1'b0;
      end
    end
  end

  // sticky event status, write one to clear, set wins
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat[0] <= zero_ch0 | (irq_stat[0] & ~(wr & hit(avs_address, `DDT_OFF_IRQ_STAT) & wd[0]));
      irq_stat[1] <= zero_ch1 | (irq_stat[1] & ~(wr & hit(avs_address, `DDT_OFF_IRQ_STAT) & wd[1]));
    end
  end

  assign irq       = |(irq_stat & irq_mask);
  assign timer_irq = (irq_enable_ch1 & zero_flag_ch1) | (irq_enable_ch0 & zero_flag_ch0);

  // timer output pin
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tout <= 1'b0;
    end else begin
      case (out_ctrl)
        `DDT_OC_TOGGLE: begin
          if (zero_ch1) begin
            tout <= ~tout;
          end
        end
        `DDT_OC_LOW:  tout <= 1'b0;
        `DDT_OC_HIGH: tout <= 1'b1;
        default:      tout <= tout;
      endcase
    end
  end

  assign shared_addr_timer_pin = (out_ctrl == `DDT_OC_ADDR) ? addr_line : tout;

  // read data
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h00000000;
    end else if (rd) begin
      case (avs_address)
        `DDT_OFF_CTRL:     avs_readdata <= {24'h000000, zero_flag_ch1, zero_flag_ch0, ctrl};
        `DDT_OFF_CNT0_LO:  avs_readdata <= {24'h000000, count_reg_ch0[7:0]};
        `DDT_OFF_CNT0_HI:  avs_readdata <= {24'h000000, count_reg_ch0[15:8]};
        `DDT_OFF_RLD0_LO:  avs_readdata <= {24'h000000, reload_timer_ch0[7:0]};
        `DDT_OFF_RLD0_HI:  avs_readdata <= {24'h000000, reload_timer_ch0[15:8]};
        `DDT_OFF_CNT1_LO:  avs_readdata <= {24'h000000, count_reg_ch1[7:0]};
        `DDT_OFF_CNT1_HI:  avs_readdata <= {24'h000000, count_reg_ch1[15:8]};
        `DDT_OFF_RLD1_LO:  avs_readdata <= {24'h000000, reload_timer_ch1[7:0]};
        `DDT_OFF_RLD1_HI:  avs_readdata <= {24'h000000, reload_timer_ch1[15:8]};
        `DDT_OFF_IRQ_STAT: avs_readdata <= {30'h00000000, irq_stat};
        `DDT_OFF_IRQ_MASK: avs_readdata <= {30'h00000000, irq_mask};
        default:           avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule // ddt_top

// [bench/ddtc_monitor.sv]
// port-level assertion checker of the dual down-count timer
module ddtc_monitor (
  input logic        clk,
  input logic        rst_b,
  input logic [3:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0]  avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic        addr_line,
  input logic        shared_addr_timer_pin,
  input logic        timer_irq,
  input logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] ctrl;
  logic [1:0] mask;
  wire        wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shadow of the writable control bits and the interrupt mask
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= 6'h00;
      mask <= 2'h0;
    end else if (wr_ok) begin
      if (avs_address == 4'h0) ctrl <= avs_writedata[5:0];
      if (avs_address == 4'hA) mask <= avs_writedata[1:0];
    end
  end
  a_one_wait: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
    |-> avs_waitrequest ##1 !avs_waitrequest) else $error("request not answered after one wait");
  a_addr_mode: assert property (ctrl[3:2] == 2'h0 |-> shared_addr_timer_pin == addr_line)
    else $error("pin does not follow the address line");
  a_low_mode: assert property (ctrl[3:2] == 2'h2 && $past(ctrl[3:2]) == 2'h2 |-> !shared_addr_timer_pin)
    else $error("pin not low in low mode");
  a_high_mode: assert property (ctrl[3:2] == 2'h3 && $past(ctrl[3:2]) == 2'h3 |-> shared_addr_timer_pin)
    else $error("pin not high in high mode");
  a_irq_off: assert property (ctrl[5:4] == 2'h0 |-> !timer_irq)
    else $error("timer interrupt with both enables off");
  a_mask_off: assert property (mask == 2'h0 |-> !irq)
    else $error("interrupt with empty mask");
  a_no_count: assert property (ctrl[1:0] == 2'h0 && $past(ctrl[1:0]) == 2'h0
    && $past(ctrl[1:0], 3) == 2'h0 && $stable(ctrl[5:4]) |-> !$rose(timer_irq))
    else $error("zero reached while stopped");
  a_ctrl_read: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
    |-> avs_readdata[5:0] == ctrl) else $error("control readback differs");
endmodule // ddtc_monitor

bind ddt_top ddtc_monitor mon (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .addr_line(addr_line),
  .shared_addr_timer_pin(shared_addr_timer_pin), .timer_irq(timer_irq), .irq(irq));

// [bench/dual_downcount_timer_control_test.sv]
// self-checking bench of the dual down-count timer
module dual_downcount_timer_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        addr_line = 1'b0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire         pin;
  wire         timer_irq;
  wire         irq;
  int          miscompares = 0;
  int          n_checks = 0;
  logic [31:0] rd;
  logic [7:0]  c;
  int          n;
  always #2 clk = ~clk;
  always @(posedge clk) addr_line <= 1'($urandom);
  ddt_top #(.STEP_DIV(16'h0002)) uut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .addr_line(addr_line), .shared_addr_timer_pin(pin), .timer_irq(timer_irq), .irq(irq));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle, held until waitrequest is seen low
  task xfer(input logic [3:0] a, input logic w, input logic [7:0] d, input logic [3:0] be);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    if (i >= 50) miscompares++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(20000 * 4);
    miscompares++;
    print_verdict;
  end
  initial begin
    void'($urandom(60));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    xfer(4'h0, 1'b0, 8'h00, 4'hF);
    chk(rd, 32'h0);
    @(negedge clk);
    chk(pin, addr_line);
    xfer(4'h0, 1'b1, 8'h03, 4'hE);
    xfer(4'h0, 1'b0, 8'h00, 4'hF);
    chk(rd, 32'h0);
    xfer(4'hF, 1'b0, 8'h00, 4'hF);
    chk(rd, 32'h0);
    for (int ch = 0; ch < 2; ch++) begin
      n = 1 + $urandom % 8;
      c = (8'h11 << ch) | (ch ? 8'h04 : 8'h00);
      xfer(4'h1 + 4 * ch, 1'b1, n[7:0], 4'hF);
      xfer(4'h2 + 4 * ch, 1'b1, 8'h00, 4'hF);
      xfer(4'h1 + 4 * ch, 1'b0, 8'h00, 4'hF);
      chk(rd, n);
      xfer(4'h0, 1'b1, c, 4'hF);
      for (int i = 0; i < 200 && timer_irq !== 1'b1; i++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk(timer_irq, 1'b1);
      chk(irq, 1'b0);
      if (ch == 1) chk(pin, 1'b1);
      xfer(4'h1 + 4 * ch, 1'b0, 8'h00, 4'hF);
      xfer(4'h0, 1'b0, 8'h00, 4'hF);
      chk(rd, c | (8'h40 << ch));
      xfer(4'hA, 1'b1, 8'h01 << ch, 4'hF);
      @(negedge clk);
      chk(irq, 1'b1);
      xfer(4'h9, 1'b1, 8'h01 << ch, 4'hF);
      @(negedge clk);
      chk(irq, 1'b0);
      xfer(4'h2 + 4 * ch, 1'b0, 8'h00, 4'hF);
      chk(rd, 32'hFF);
      xfer(4'h0, 1'b0, 8'h00, 4'hF);
      chk(rd, c);
      xfer(4'h0, 1'b1, 8'h00, 4'hF);
    end
    for (int m = 0; m < 4; m++) begin
      xfer(4'h0, 1'b1, m << 2, 4'hF);
      repeat (2) @(negedge clk);
      chk(pin, m == 0 ? addr_line : m != 2);
    end
    xfer(4'h0, 1'b1, 8'h3F, 4'hF);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    xfer(4'h0, 1'b0, 8'h00, 4'hF);
    chk(rd, 32'h0);
    xfer(4'h5, 1'b0, 8'h00, 4'hF);
    chk(rd, 32'hFF);
    @(negedge clk);
    chk(pin, addr_line);
    print_verdict;
  end
endmodule // dual_downcount_timer_control_test
